// ---- core/pamc_pkg.sv ----
// pamc_pkg: register map, field layouts and constants of the pulse accumulator block
package pamc_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_A_CTL    = 8'ha0;
   localparam logic [7:0] IDX_A_FLG    = 8'ha1;
   localparam logic [7:0] IDX_CNT3     = 8'ha2;
   localparam logic [7:0] IDX_CNT2     = 8'ha3;
   localparam logic [7:0] IDX_CNT1     = 8'ha4;
   localparam logic [7:0] IDX_CNT0     = 8'ha5;
   localparam logic [7:0] IDX_MC_CTL   = 8'ha6;
   localparam logic [7:0] IDX_MC_FLG   = 8'ha7;
   localparam logic [7:0] IDX_BYTE_EN  = 8'ha8;
   localparam logic [7:0] IDX_CAP_SYS  = 8'hab;
   localparam logic [7:0] IDX_B_CTL    = 8'hb0;
   localparam logic [7:0] IDX_B_FLG    = 8'hb1;
   localparam logic [7:0] IDX_DOWN_CNT = 8'hb6;
   localparam logic [7:0] IDX_TMR_SYS  = 8'h86;
   localparam logic [7:0] IDX_WORD_A   = 8'hc0;
   localparam logic [7:0] IDX_WORD_B   = 8'hc1;
   localparam logic [7:0] IDX_HOLD     = 8'hc2;

   // flag bit positions
   localparam int A_WRAP_BIT = 1;
   localparam int A_EDGE_BIT = 0;
   localparam int B_WRAP_BIT = 1;
   localparam int MC_UF_BIT  = 7;

   localparam logic [7:0]  BYTE_MAX  = 8'hff;
   localparam logic [15:0] MC_PRESET = 16'hffff;
   localparam logic [15:0] MC_ONE    = 16'h0001;
   localparam logic [15:0] MC_ZERO   = 16'h0000;
   localparam logic [3:0]  ALL_ARMED = 4'hf;
   localparam logic [5:0]  DIV64_LIMIT = 6'h3f;
   // modulus prescaler terminal counts for divide by 1, 4, 8, 16
   localparam logic [3:0][3:0] MC_DIV_LIMIT = {4'hf, 4'h7, 4'h3, 4'h0};

   typedef enum logic [1:0] {
      PAMC_SRC_PRESCALER = 2'h0,
      PAMC_SRC_ACCUM     = 2'h1,
      PAMC_SRC_DIV256    = 2'h2,
      PAMC_SRC_DIV65536  = 2'h3
   } pamc_source_type;

   typedef struct packed {
      logic            reserved;
      logic            accum_a_system_enable;
      logic            accum_gated_select;
      logic            accum_polarity_select;
      pamc_source_type timer_source_sel;
      logic            accum_wrap_irq_enable;
      logic            input_edge_irq_enable;
   } pamc_a_ctl_type;

   typedef struct packed {
      logic       underflow_irq_enable;
      logic       reload_mode;
      logic       read_load_select;
      logic       force_capture_latch;
      logic       force_count_load;
      logic       down_counter_enable;
      logic [1:0] down_prescale;
   } pamc_mc_ctl_type;

   typedef struct packed {
      logic       main_timer_enable;
      logic [1:0] reserved_hi;
      logic       fast_flag_clear;
      logic [3:0] reserved_lo;
   } pamc_tmr_sys_type;

   typedef struct packed {
      logic [5:0] reserved;
      logic       holding_buffer_enable;
      logic       latch_or_queue_select;
   } pamc_cap_sys_type;

   typedef struct packed {
      logic       reserved;
      logic       accum_b_system_enable;
      logic [4:0] reserved_lo;
      logic       accum_b_wrap_irq_enable;
   } pamc_b_ctl_type;
endpackage

// ---- core/pamc_divider.sv ----
// pamc_divider: enable-gated clock divider producing one-cycle tick pulses
module pamc_divider #(
   parameter int WIDTH = 6
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             enable,
   input  wire logic             clear,
   input  wire logic [WIDTH-1:0] limit,
   output logic                  tick
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
   } pamc_div_state_type;

   pamc_div_state_type s;
   pamc_div_state_type next_s;

   // >= so that a smaller limit taking over mid-count cannot stall the divider
   assign tick = enable & ~clear & (s.count >= limit);

   always_comb begin
      next_s = s;
      if (clear || !enable || tick) begin
         next_s.count = '0;
      end else begin
         next_s.count = s.count + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ---- core/pamc_edge.sv ----
// pamc_edge: rising and falling edge detector for one synchronous input pin
module pamc_edge (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);
   typedef struct packed {
      logic prev;
   } pamc_edge_state_type;

   pamc_edge_state_type s;
   pamc_edge_state_type next_s;

   assign rise = pin & ~s.prev;
   assign fall = ~pin & s.prev;

   always_comb begin
      next_s = s;
      next_s.prev = pin;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ---- core/pamc_top.sv ----
// pamc_top: pulse accumulators and modulus down-counter with an apb register slave
//
// Added by the designer: the APB slave port.
module pamc_top (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic [pamc_pkg::ADDR_W-1:0] paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [pamc_pkg::DATA_W-1:0] pwdata,
   output logic      [pamc_pkg::DATA_W-1:0] prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        accum_input_pin,
   input  wire logic [3:0]                  capture_pins,
   input  wire logic [3:0]                  capture_event,
   input  wire logic [3:0]                  capture_rising,
   input  wire logic                        timer_prescale_tick,
   output logic                             timer_clock_tick,
   output logic                             capture_latch,
   output logic                             accum_wrap_irq,
   output logic                             input_edge_irq,
   output logic                             accum_b_wrap_irq,
   output logic                             underflow_irq
);
   import pamc_pkg::*;

   typedef struct packed {
      pamc_a_ctl_type   a_ctl;
      pamc_mc_ctl_type  mc_ctl;
      pamc_tmr_sys_type tmr;
      pamc_cap_sys_type cap;
      pamc_b_ctl_type   b_ctl;
      logic [3:0]       byte_en;
      logic [3:0][7:0]  accum;
      logic [3:0][7:0]  hold;
      logic             wrap_a;
      logic             edge_a;
      logic             wrap_b;
      logic             underflow;
      logic [3:0]       polarity;
      logic [3:0]       pol_armed;
      logic [15:0]      down_count;
      logic [15:0]      load;
      logic [1:0]       active_pr;
      logic [31:0]      rdata;
      logic             ready;
      logic             slverr;
      logic             timer_tick;
      logic             latch_pulse;
      logic             irq_wrap_a;
      logic             irq_edge_a;
      logic             irq_wrap_b;
      logic             irq_underflow;
   } pamc_state_type;

   pamc_state_type s;
   pamc_state_type next_s;

   logic [4:0] rise;
   logic [4:0] fall;
   logic [4:0] pins;
   logic       div64_tick;
   logic       mc_tick;
   logic       mc_clear;

   assign pins = {accum_input_pin, capture_pins};

   // pin 4 is the accumulator A input, pins 3..0 feed the byte accumulators
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_pin
         pamc_edge u_edge (
            .pclk    (pclk),
            .presetn (presetn),
            .pin     (pins[g]),
            .rise    (rise[g]),
            .fall    (fall[g])
         );
      end
   endgenerate

   // timer prescaler stage: silent unless the main timer runs
   pamc_divider #(.WIDTH(6)) u_div64 (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (s.tmr.main_timer_enable),
      .clear   (1'b0),
      .limit   (DIV64_LIMIT),
      .tick    (div64_tick)
   );

   pamc_divider #(.WIDTH(4)) u_mc_div (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (s.mc_ctl.down_counter_enable),
      .clear   (mc_clear),
      .limit   (MC_DIV_LIMIT[s.active_pr]),
      .tick    (mc_tick)
   );

   logic [7:0] idx;
   logic       wr;
   logic       rd;
   logic       acc_a;
   logic       acc_b;
   logic       acc_mc;
   logic       a_en;
   logic       b_en;
   logic       pol;
   logic       a_edge;
   logic       a_inc;
   logic       b_edge;
   logic [3:0] own_edge;
   logic [3:0] inc;
   logic       wrap_set_a;
   logic       wrap_set_b;
   logic       cnt_write;
   logic       force_load;
   logic       uf_set;
   logic       latch_ev;
   logic       src_tick;
   logic [7:0] wb;

   assign idx    = paddr[ADDR_W-1:2];
   assign wb     = pwdata[7:0];
   assign wr     = psel & penable & s.ready & pwrite;
   assign rd     = psel & penable & s.ready & ~pwrite;
   assign acc_a  = (wr | rd) & (idx == IDX_CNT3 || idx == IDX_CNT2 || idx == IDX_WORD_A);
   assign acc_b  = (wr | rd) & (idx == IDX_CNT1 || idx == IDX_CNT0 || idx == IDX_WORD_B);
   assign acc_mc = (wr | rd) & (idx == IDX_DOWN_CNT);
   assign a_en   = s.a_ctl.accum_a_system_enable;
   assign b_en   = s.b_ctl.accum_b_system_enable;
   assign pol    = s.a_ctl.accum_polarity_select;

   // the trailing gate edge is the same edge that event mode counts
   assign a_edge = pol ? rise[4] : fall[4];
   assign a_inc  = a_en & (s.a_ctl.accum_gated_select ?
                   (div64_tick & (pol ? ~pins[4] : pins[4])) : a_edge);

   // chained B ignores the byte enables of bytes 1 and 0
   assign b_edge = pol ? rise[0] : fall[0];

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         own_edge[k] = s.byte_en[k] & (pol ? rise[k] : fall[k]);
      end
      inc[0] = b_en ? b_edge : own_edge[0];
      inc[1] = b_en ? (b_edge & (s.accum[0] == BYTE_MAX)) : own_edge[1];
      inc[2] = a_en ? a_inc : own_edge[2];
      inc[3] = a_en ? (a_inc & (s.accum[2] == BYTE_MAX)) : own_edge[3];
   end

   assign wrap_set_a = inc[3] & (s.accum[3] == BYTE_MAX);
   assign wrap_set_b = b_en & inc[1] & (s.accum[1] == BYTE_MAX);

   assign cnt_write  = wr & (idx == IDX_DOWN_CNT);
   assign force_load = wr & (idx == IDX_MC_CTL) & wb[3] & s.mc_ctl.down_counter_enable;
   assign mc_clear   = cnt_write | force_load;
   assign uf_set     = s.mc_ctl.down_counter_enable & mc_tick & (s.down_count == MC_ONE);
   assign latch_ev   = s.cap.holding_buffer_enable & s.cap.latch_or_queue_select &
                       ((wr & (idx == IDX_MC_CTL) & wb[4]) | uf_set |
                        (cnt_write & (pwdata[15:0] == MC_ZERO)));

   always_comb begin
      case (s.a_ctl.timer_source_sel)
         PAMC_SRC_PRESCALER : src_tick = timer_prescale_tick;
         PAMC_SRC_ACCUM     : src_tick = a_inc;
         PAMC_SRC_DIV256    : src_tick = a_inc & (s.accum[2] == BYTE_MAX);
         PAMC_SRC_DIV65536  : src_tick = a_inc & (s.accum[2] == BYTE_MAX) &
                                         (s.accum[3] == BYTE_MAX);
         default            : src_tick = timer_prescale_tick;
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.ready = psel & ~penable;
      next_s.slverr = 1'b0;
      next_s.rdata = '0;
      // read data is assembled in the setup cycle so that it can leave a flip-flop
      if (psel && !penable) begin
         case (idx)
            IDX_A_CTL    : next_s.rdata[7:0] = s.a_ctl;
            IDX_A_FLG    : next_s.rdata[7:0] = {6'h00, s.wrap_a, s.edge_a};
            IDX_CNT3     : next_s.rdata[7:0] = s.accum[3];
            IDX_CNT2     : next_s.rdata[7:0] = s.accum[2];
            IDX_CNT1     : next_s.rdata[7:0] = s.accum[1];
            IDX_CNT0     : next_s.rdata[7:0] = s.accum[0];
            IDX_MC_CTL   : next_s.rdata[7:0] = s.mc_ctl;
            IDX_MC_FLG   : next_s.rdata[7:0] = {s.underflow, 3'h0, s.polarity};
            IDX_BYTE_EN  : next_s.rdata[7:0] = {4'h0, s.byte_en};
            IDX_CAP_SYS  : next_s.rdata[7:0] = s.cap;
            IDX_B_CTL    : next_s.rdata[7:0] = s.b_ctl;
            IDX_B_FLG    : next_s.rdata[7:0] = {6'h00, s.wrap_b, 1'b0};
            IDX_TMR_SYS  : next_s.rdata[7:0] = s.tmr;
            IDX_WORD_A   : next_s.rdata[15:0] = {s.accum[3], s.accum[2]};
            IDX_WORD_B   : next_s.rdata[15:0] = {s.accum[1], s.accum[0]};
            IDX_HOLD     : next_s.rdata = s.hold;
            IDX_DOWN_CNT : next_s.rdata[15:0] = s.mc_ctl.read_load_select ?
                                                s.load : s.down_count;
            default      : next_s.slverr = 1'b1;
         endcase
      end

      // byte accumulators count; a bus write below takes precedence
      for (int k = 0; k < 4; k++) begin
         if (inc[k]) begin
            next_s.accum[k] = s.accum[k] + 8'h01;
         end
      end

      if (wr) begin
         case (idx)
            IDX_A_CTL   : next_s.a_ctl = pamc_a_ctl_type'(wb & 8'h7f);
            IDX_CNT3    : next_s.accum[3] = wb;
            IDX_CNT2    : next_s.accum[2] = wb;
            IDX_CNT1    : next_s.accum[1] = wb;
            IDX_CNT0    : next_s.accum[0] = wb;
            IDX_MC_CTL  : begin
               // force bits are actions and never stored
               next_s.mc_ctl = pamc_mc_ctl_type'(wb & 8'he7);
            end
            IDX_BYTE_EN : next_s.byte_en = wb[3:0];
            IDX_CAP_SYS : next_s.cap = pamc_cap_sys_type'(wb & 8'h03);
            IDX_B_CTL   : next_s.b_ctl = pamc_b_ctl_type'(wb & 8'h41);
            IDX_TMR_SYS : next_s.tmr = pamc_tmr_sys_type'(wb & 8'h90);
            IDX_WORD_A  : next_s.accum[3:2] = pwdata[15:0];
            IDX_WORD_B  : next_s.accum[1:0] = pwdata[15:0];
            default     : next_s.tmr = next_s.tmr;
         endcase
      end

      if (latch_ev) begin
         next_s.hold = s.accum;
         next_s.accum = '0;
      end

      // flags: set wins over any clear in the same cycle
      next_s.wrap_a = (s.wrap_a & ~(wr & (idx == IDX_A_FLG) & wb[A_WRAP_BIT]) &
                       ~(acc_a & s.tmr.fast_flag_clear)) | wrap_set_a;
      next_s.edge_a = (s.edge_a & ~(wr & (idx == IDX_A_FLG) & wb[A_EDGE_BIT]) &
                       ~(acc_a & s.tmr.fast_flag_clear)) | (a_en & a_edge);
      next_s.wrap_b = (s.wrap_b & ~(wr & (idx == IDX_B_FLG) & wb[B_WRAP_BIT]) &
                       ~(acc_b & s.tmr.fast_flag_clear)) | wrap_set_b;
      next_s.underflow = (s.underflow & ~(wr & (idx == IDX_MC_FLG) & wb[MC_UF_BIT]) &
                          ~(acc_mc & s.tmr.fast_flag_clear)) | uf_set;

      // reading the holding registers rearms the first-edge polarity capture
      for (int k = 0; k < 4; k++) begin
         if (s.pol_armed[k] && capture_event[k]) begin
            next_s.polarity[k] = capture_rising[k];
            next_s.pol_armed[k] = 1'b0;
         end
      end
      if (rd && idx == IDX_HOLD) begin
         next_s.pol_armed = ALL_ARMED;
      end

      // modulus down-counter
      if (cnt_write) begin
         next_s.load = pwdata[15:0];
      end
      if (!s.mc_ctl.down_counter_enable) begin
         next_s.down_count = MC_PRESET;
      end else if (cnt_write || force_load) begin
         next_s.down_count = cnt_write ? pwdata[15:0] : s.load;
         next_s.active_pr = s.mc_ctl.down_prescale;
      end else if (mc_tick) begin
         if (s.down_count == MC_ONE) begin
            next_s.down_count = s.mc_ctl.reload_mode ? s.load : MC_ZERO;
         end else if (s.down_count != MC_ZERO) begin
            next_s.down_count = s.down_count - MC_ONE;
         end else if (s.mc_ctl.reload_mode) begin
            next_s.down_count = s.load;
         end
      end

      next_s.timer_tick = a_en ? src_tick : timer_prescale_tick;
      next_s.latch_pulse = latch_ev;
      next_s.irq_wrap_a = next_s.wrap_a & next_s.a_ctl.accum_wrap_irq_enable;
      next_s.irq_edge_a = next_s.edge_a & next_s.a_ctl.input_edge_irq_enable;
      next_s.irq_wrap_b = next_s.wrap_b & next_s.b_ctl.accum_b_wrap_irq_enable;
      next_s.irq_underflow = next_s.underflow & next_s.mc_ctl.underflow_irq_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.pol_armed <= ALL_ARMED;
         s.down_count <= MC_PRESET;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.slverr;
   assign timer_clock_tick = s.timer_tick;
   assign capture_latch = s.latch_pulse;
   assign accum_wrap_irq = s.irq_wrap_a;
   assign input_edge_irq = s.irq_edge_a;
   assign accum_b_wrap_irq = s.irq_wrap_b;
   assign underflow_irq = s.irq_underflow;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_chain_a: assert property (a_en && a_inc && s.accum[2] == BYTE_MAX && !wr && !latch_ev
      |=> s.accum[2] == 8'h00 && s.accum[3] == $past(s.accum[3]) + 8'h01)
      else $error("chained carry into high byte lost");
   no_edge_flag_a: assert property (!a_en && !s.edge_a |=> !s.edge_a)
      else $error("edge flag set while system A disabled");
   gate_stop_a: assert property (!s.tmr.main_timer_enable |-> !div64_tick)
      else $error("divide-by-64 tick while main timer disabled");
   clk_sel_a: assert property (a_en && s.a_ctl.timer_source_sel == PAMC_SRC_ACCUM
      |=> s.timer_tick == $past(a_inc))
      else $error("accumulator clock not routed to timer");
   clk_force_a: assert property (!a_en |=> timer_clock_tick == $past(timer_prescale_tick))
      else $error("timer not clocked from prescaler");
   wrap_irq_a: assert property (wrap_set_a && s.a_ctl.accum_wrap_irq_enable
      && !(wr && idx == IDX_A_CTL) |=> s.wrap_a ##0 accum_wrap_irq)
      else $error("wrap flag or request missing");
   fast_clear_a: assert property (acc_a && s.tmr.fast_flag_clear && !wrap_set_a && !a_edge
      |=> !s.wrap_a && !s.edge_a)
      else $error("fast clear left a flag");
   underflow_a: assert property (uf_set |=> s.underflow)
      else $error("underflow flag not set");
   one_shot_a: assert property (s.mc_ctl.down_counter_enable && !s.mc_ctl.reload_mode
      && s.down_count == MC_ZERO && !wr |=> s.down_count == MC_ZERO)
      else $error("one-shot counter left zero");
   read_load_a: assert property (psel && !penable && idx == IDX_DOWN_CNT
      && s.mc_ctl.read_load_select |=> prdata[15:0] == $past(s.load))
      else $error("load value not returned");
   latch_clear_a: assert property (latch_ev |=> s.accum == '0 && capture_latch)
      else $error("latch did not clear accumulators");
   force_load_a: assert property (force_load && !cnt_write
      |=> s.down_count == $past(s.load))
      else $error("force load failed");
   preset_a: assert property (!s.mc_ctl.down_counter_enable && !(wr && idx == IDX_MC_CTL)
      |=> s.down_count == MC_PRESET)
      else $error("disabled counter not preset");
endmodule

// ---- verification/pamc_pin_drv.sv ----
// pamc_pin_drv: pulse source standing in for the signal on the accumulator pin
module pamc_pin_drv (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       go,
   input  wire logic [7:0] npulse,
   output logic            pin,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] half_left;
   logic [1:0] dwell;
   assign busy = (half_left != 9'h000);
   // each level is held four cycles before the pin toggles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin <= 1'b0;
         half_left <= 9'h000;
         dwell <= 2'h0;
      end else if (go) begin
         half_left <= {npulse, 1'b0};
         dwell <= 2'h0;
      end else if (busy) begin
         dwell <= dwell + 2'h1;
         if (dwell == 2'h3) begin
            pin <= ~pin;
            half_left <= half_left - 9'h001;
         end
      end
   end
endmodule

// ---- verification/tb.sv ----
// tb: register, accumulator and down-counter checks of pamc_top
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [9:0] a; logic [7:0] w; logic [7:0] e; logic r;} pamc_row_type;
   localparam pamc_row_type ROWS [5] = '{'{10'h280, 8'h5c, 8'h5c, 1'b0},
      '{10'h288, 8'ha5, 8'ha5, 1'b0}, '{10'h298, 8'h18, 8'h00, 1'b0},
      '{10'h2a0, 8'h0c, 8'h0c, 1'b0}, '{10'h3fc, 8'h5a, 8'h00, 1'b1}};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, go, pin, busy;
   logic        tclk, latch, wirq, eirq, birq, uirq, ptick;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  npulse;
   int          failures = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          n;
   int          tcnt = 0;
   int          lcnt = 0;
   pamc_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .accum_input_pin(pin), .capture_pins({3'h0, pin}),
      .capture_event(4'h0), .capture_rising(4'h0), .timer_prescale_tick(ptick),
      .timer_clock_tick(tclk),
      .capture_latch(latch), .accum_wrap_irq(wirq), .input_edge_irq(eirq),
      .accum_b_wrap_irq(birq), .underflow_irq(uirq));
   pamc_pin_drv i_pin (.pclk(pclk), .presetn(presetn), .go(go), .npulse(npulse), .pin(pin),
      .busy(busy));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [9:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // the access ends only at a rising edge that sees pready high
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulses(input logic [7:0] cnt);
      int k;
      k = 0;
      @(posedge pclk);
      npulse <= cnt;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      do begin
         @(posedge pclk);
         k++;
      end while (busy && k < 3000);
      // margin for the pin edge detector and accumulator before the count is read
      repeat (4) @(posedge pclk);
   endtask
   // one-cycle output pulses are counted at the edges that see them
   always @(posedge pclk) begin
      if (tclk === 1'b1) begin
         tcnt <= tcnt + 1;
      end
      if (latch === 1'b1) begin
         lcnt <= lcnt + 1;
      end
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         give_verdict;
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, go, paddr, pwdata, npulse, ptick} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(10'h2d8, 1'b0, 32'h0);
      chk(rd, 32'hffff);
      foreach (ROWS[i]) begin
         apb(ROWS[i].a, 1'b1, {24'h0, ROWS[i].w});
         apb(ROWS[i].a, 1'b0, 32'h0);
         chk(rd, {24'h0, ROWS[i].e});
         chk({31'h0, er}, {31'h0, ROWS[i].r});
      end
      $display("register table finished");
      apb(10'h280, 1'b1, 32'h44);
      apb(10'h300, 1'b1, 32'h0);
      n = tcnt;
      pulses(8'h05);
      apb(10'h300, 1'b0, 32'h0);
      chk(rd, 32'h5);
      chk(tcnt - n, 32'h5);
      apb(10'h284, 1'b0, 32'h0);
      chk(rd, 32'h1);
      apb(10'h284, 1'b1, 32'h1);
      apb(10'h284, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(10'h280, 1'b1, 32'h53);
      apb(10'h300, 1'b1, 32'hffff);
      pulses(8'h01);
      apb(10'h300, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(10'h284, 1'b0, 32'h0);
      chk(rd, 32'h3);
      chk({31'h0, wirq}, 32'h1);
      chk({31'h0, eirq}, 32'h1);
      apb(10'h2c0, 1'b1, 32'h41);
      apb(10'h304, 1'b1, 32'hffff);
      pulses(8'h01);
      apb(10'h304, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(10'h2c4, 1'b0, 32'h0);
      chk(rd, 32'h2);
      chk({31'h0, birq}, 32'h1);
      apb(10'h218, 1'b1, 32'h10);
      apb(10'h288, 1'b0, 32'h0);
      apb(10'h284, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk({30'h0, wirq, eirq}, 32'h0);
      apb(10'h218, 1'b1, 32'h0);
      $display("accumulator test finished");
      apb(10'h298, 1'b1, 32'h84);
      apb(10'h2d8, 1'b1, 32'h3);
      n = 0;
      while (uirq !== 1'b1 && n < 100) begin
         @(negedge pclk);
         n++;
      end
      chk({31'h0, uirq}, 32'h1);
      apb(10'h29c, 1'b0, 32'h0);
      chk(rd & 32'h80, 32'h80);
      apb(10'h2d8, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(10'h298, 1'b1, 32'ha4);
      apb(10'h2d8, 1'b0, 32'h0);
      chk(rd, 32'h3);
      apb(10'h29c, 1'b1, 32'h80);
      apb(10'h29c, 1'b0, 32'h0);
      chk(rd & 32'h80, 32'h0);
      chk({31'h0, uirq}, 32'h0);
      $display("down-counter test finished");
      // the count rests at zero, so only a working force load brings a new underflow
      apb(10'h298, 1'b1, 32'h0c);
      repeat (8) @(posedge pclk);
      apb(10'h29c, 1'b0, 32'h0);
      chk(rd & 32'h80, 32'h80);
      apb(10'h2ac, 1'b1, 32'h3);
      apb(10'h300, 1'b1, 32'h1234);
      apb(10'h304, 1'b1, 32'h5678);
      n = lcnt;
      apb(10'h298, 1'b1, 32'h10);
      apb(10'h308, 1'b0, 32'h0);
      chk(rd, 32'h12345678);
      chk(lcnt - n, 32'h1);
      apb(10'h300, 1'b0, 32'h0);
      chk(rd, 32'h0);
      $display("force and latch test finished");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(10'h280, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, birq}, 32'h0);
      apb(10'h2d8, 1'b0, 32'h0);
      chk(rd, 32'hffff);
      n = tcnt;
      ptick <= 1'b1;
      repeat (3) @(posedge pclk);
      ptick <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(tcnt - n, 32'h3);
      $display("reset and prescaler test finished");
      give_verdict;
   end
endmodule
